/* pkg/pin_port_cfg.svh */
// register offsets, field positions, reset values for the pin function port
// assumes a 32-bit classic Wishbone register bus with byte addresses
`ifndef PIN_PORT_CFG_SVH
`define PIN_PORT_CFG_SVH

// register byte offsets, one aligned word each
`define OFF_PA_DATA 8'h00
`define OFF_PA_DIR 8'h04
`define OFF_PA_PULL_EN 8'h08
`define OFF_PA_PULL_DN 8'h0C
`define OFF_PA_FUNC 8'h10
`define OFF_WAKE_EN 8'h14
`define OFF_PB_DATA 8'h18
`define OFF_PB_DIR 8'h1C
`define OFF_PB_PULL_EN 8'h20
`define OFF_SYS_CTRL 8'h24
`define OFF_IRQ_STATUS 8'h28
`define OFF_IRQ_MASK 8'h2C
`define OFF_MODE_STATUS 8'h30

// field positions inside the system control and mode words
`define SYS_LF_EN_BIT 0
`define SYS_CLK_STOP_LSB 1
`define MODE_BDM_BIT 0
`define MODE_RUN_BIT 1

// widths and counts
`define PA_WIDTH 4
`define PB_WIDTH 2
`define CLK_SRC_NUM 4

// reset values
`define RST_PA 4'h0
`define RST_PB 2'h0
`define RST_MASK 4'h0
`define RST_CLK_STOP 4'h0
`define RST_LF_EN 1'b0
`define RESET_PSEUDO_VECTOR 16'hDFFE

`endif

/* pkg/pin_port_pkg.sv */
// types shared by the pin function port design
// constants come from the guarded config header
`include "pin_port_cfg.svh"
package pin_port_pkg;

  // boot strap sequence, gray coded along the path
  typedef enum logic [1:0] {
    BOOT_HOLD = 2'b00,
    BOOT_SAMPLE = 2'b01,
    BOOT_DONE = 2'b11
  } boot_t;

  // every flip-flop of the port block except the pin synchroniser stages
  typedef struct packed {
    boot_t boot;
    logic ack;
    logic [31:0] rdata;
    logic [`PA_WIDTH-1:0] pa_out;
    logic [`PA_WIDTH-1:0] pa_dir;
    logic [`PA_WIDTH-1:0] pa_pull_en;
    logic [`PA_WIDTH-1:0] pa_pull_dn;
    logic [`PA_WIDTH-1:0] pa_func;
    logic [`PA_WIDTH-1:0] wake_en;
    logic [`PB_WIDTH-1:0] pb_out;
    logic [`PB_WIDTH-1:0] pb_dir;
    logic [`PB_WIDTH-1:0] pb_pull_en;
    logic lf_en;
    logic [`CLK_SRC_NUM-1:0] clk_stop;
    logic [`PA_WIDTH-1:0] irq_status;
    logic [`PA_WIDTH-1:0] irq_mask;
    logic [`PA_WIDTH-1:0] pa_prev;
    logic [`PA_WIDTH-1:0] pa_o;
    logic [`PA_WIDTH-1:0] pa_oe;
    logic [`PA_WIDTH-1:0] pa_pu;
    logic [`PA_WIDTH-1:0] pa_pd;
    logic [`PB_WIDTH-1:0] pb_o;
    logic [`PB_WIDTH-1:0] pb_oe;
    logic [`PB_WIDTH-1:0] pb_pu;
    logic [1:0] conv_ch;
    logic [1:0] conv_sel;
    logic [1:0] timer_ch;
    logic lf_pos;
    logic lf_neg;
    logic lf_on;
    logic [`CLK_SRC_NUM-1:0] clk_run;
    logic lfo_run;
    logic background_debug_mode;
    logic run;
    logic vec_fetch;
    logic [15:0] start_addr;
    logic irq;
  } state_t;

endpackage

/* core/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; no reset so a strap is valid at reset release
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // system clock
  input wire logic [WIDTH-1:0] pin_i, // raw pin levels
  output var logic [WIDTH-1:0] level_o // filtered level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // a change is accepted only once stages two and three agree
  always_ff @(posedge clk_i) begin
    stage1 <= pin_i;
    stage2 <= stage1;
    stage3 <= stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        level_o[i] <= stage3[i];
      end
    end
  end
endmodule
`default_nettype wire

/* core/pin_port.sv */
// pin function port: port A/B I/O, peripheral routing, wake flags, strap
// assumes a classic Wishbone master and asynchronous pins on clk_i domain
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_port_cfg.svh"
module pin_port (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output var logic [31:0] wb_dat_o, // read data
  output var logic wb_ack_o, // acknowledge
  input wire logic [3:0] port_a_pins_i, // port A pin levels
  output var logic [3:0] port_a_pins_o, // port A drive value
  output var logic [3:0] port_a_pins_oe_o, // port A drive enable
  output var logic [3:0] port_a_pullup_o, // port A pullup enable
  output var logic [3:0] port_a_pulldown_o, // port A pulldown enable
  input wire logic [1:0] port_b_pins_i, // port B pin levels
  output var logic [1:0] port_b_pins_o, // port B drive value
  output var logic [1:0] port_b_pins_oe_o, // port B drive enable
  output var logic [1:0] port_b_pullup_o, // port B pullup enable
  input wire logic debug_mode_select_pin_i, // debug strap pin
  input wire logic lf_input_pos_i, // LF coil positive pin
  input wire logic lf_input_neg_i, // LF coil negative pin
  output var logic lf_pos_o, // gated positive to receiver
  output var logic lf_neg_o, // gated negative to receiver
  output var logic lf_receiver_enable_o, // receiver enable
  output var logic [1:0] conv_ch_o, // converter channel levels
  output var logic [1:0] conv_sel_o, // converter channel routed
  input wire logic [1:0] timer_out_i, // timer channel drive value
  input wire logic [1:0] timer_oe_i, // timer channel drives pin
  output var logic [1:0] timer_ch_o, // timer channel input levels
  output var logic [3:0] clk_run_o, // per-source clock enables
  output var logic lfo_run_o, // low-frequency oscillator runs
  output var logic bdm_mode_o, // background debug mode
  output var logic run_mode_o, // normal run mode
  output var logic vector_fetch_o, // pulse: fetch reset vector
  output var logic [15:0] start_addr_o, // pseudo-vector address
  output var logic irq_o // keyboard interrupt, level
);
  pin_port_pkg::state_t r;
  pin_port_pkg::state_t next_r;
  logic [8:0] pin_level;
  logic [3:0] pa_s;
  logic [1:0] pb_s;
  logic dbg_s;
  logic lf_pos_s;
  logic lf_neg_s;
  logic bus_req;
  logic wr_lane;
  logic [3:0] pd_eff;
  logic [3:0] kbi_edge;
  logic [3:0] kbi_set;
  logic [3:0] kbi_clr;

  // all pins pass the same three-stage filter
  pin_sync #(
    .WIDTH(9)
  ) u_sync (
    .clk_i(clk_i),
    .pin_i({lf_input_neg_i, lf_input_pos_i, debug_mode_select_pin_i,
            port_b_pins_i, port_a_pins_i}),
    .level_o(pin_level)
  );
  assign pa_s = pin_level[3:0];
  assign pb_s = pin_level[5:4];
  assign dbg_s = pin_level[6];
  assign lf_pos_s = pin_level[7];
  assign lf_neg_s = pin_level[8];

  // bus request and low byte lane; registers live in the low byte only
  assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign wr_lane = bus_req & wb_we_i & wb_sel_i[0];

  // pulldown only with wake enabled and pin not routed away
  assign pd_eff = r.pa_pull_dn & r.wake_en & ~r.pa_func;
  // active edge: falling when pulled up, rising when pulled down
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      kbi_edge[i] = pd_eff[i] ? (pa_s[i] & ~r.pa_prev[i]) : (~pa_s[i] & r.pa_prev[i]);
    end
  end
  assign kbi_set = kbi_edge & r.wake_en & ~r.pa_func;
  // status read clears what was visible when the answer went out
  assign kbi_clr = (bus_req & ~wb_we_i && wb_adr_i == `OFF_IRQ_STATUS) ? r.irq_status : 4'h0;

  // next-state logic for every register of the block except the pin synchroniser stages
  always_comb begin
    next_r = r;
    next_r.ack = bus_req;
    next_r.pa_prev = pa_s;
    // set wins over a read-clear in the same cycle
    next_r.irq_status = (r.irq_status & ~kbi_clr) | kbi_set;

    // register writes, decoded by address
    if (wr_lane) begin
      if (wb_adr_i == `OFF_PA_DATA) begin
        next_r.pa_out = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_PA_DIR) begin
        next_r.pa_dir = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_PA_PULL_EN) begin
        next_r.pa_pull_en = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_PA_PULL_DN) begin
        next_r.pa_pull_dn = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_PA_FUNC) begin
        next_r.pa_func = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_WAKE_EN) begin
        next_r.wake_en = wb_dat_i[3:0];
      end else if (wb_adr_i == `OFF_PB_DATA) begin
        next_r.pb_out = wb_dat_i[1:0];
      end else if (wb_adr_i == `OFF_PB_DIR) begin
        next_r.pb_dir = wb_dat_i[1:0];
      end else if (wb_adr_i == `OFF_PB_PULL_EN) begin
        next_r.pb_pull_en = wb_dat_i[1:0];
      end else if (wb_adr_i == `OFF_SYS_CTRL) begin
        next_r.lf_en = wb_dat_i[`SYS_LF_EN_BIT];
        next_r.clk_stop = wb_dat_i[`SYS_CLK_STOP_LSB +: 4];
      end else if (wb_adr_i == `OFF_IRQ_MASK) begin
        next_r.irq_mask = wb_dat_i[3:0];
      end
    end

    // register reads; unmapped addresses answer zero
    next_r.rdata = 32'h0000_0000;
    if (bus_req & ~wb_we_i) begin
      if (wb_adr_i == `OFF_PA_DATA) begin
        next_r.rdata[3:0] = pa_s;
      end else if (wb_adr_i == `OFF_PA_DIR) begin
        next_r.rdata[3:0] = r.pa_dir;
      end else if (wb_adr_i == `OFF_PA_PULL_EN) begin
        next_r.rdata[3:0] = r.pa_pull_en;
      end else if (wb_adr_i == `OFF_PA_PULL_DN) begin
        next_r.rdata[3:0] = r.pa_pull_dn;
      end else if (wb_adr_i == `OFF_PA_FUNC) begin
        next_r.rdata[3:0] = r.pa_func;
      end else if (wb_adr_i == `OFF_WAKE_EN) begin
        next_r.rdata[3:0] = r.wake_en;
      end else if (wb_adr_i == `OFF_PB_DATA) begin
        next_r.rdata[1:0] = pb_s;
      end else if (wb_adr_i == `OFF_PB_DIR) begin
        next_r.rdata[1:0] = r.pb_dir;
      end else if (wb_adr_i == `OFF_PB_PULL_EN) begin
        next_r.rdata[1:0] = r.pb_pull_en;
      end else if (wb_adr_i == `OFF_SYS_CTRL) begin
        next_r.rdata[`SYS_LF_EN_BIT] = r.lf_en;
        next_r.rdata[`SYS_CLK_STOP_LSB +: 4] = r.clk_stop;
      end else if (wb_adr_i == `OFF_IRQ_STATUS) begin
        next_r.rdata[3:0] = r.irq_status;
      end else if (wb_adr_i == `OFF_IRQ_MASK) begin
        next_r.rdata[3:0] = r.irq_mask;
      end else if (wb_adr_i == `OFF_MODE_STATUS) begin
        next_r.rdata[`MODE_BDM_BIT] = r.background_debug_mode;
        next_r.rdata[`MODE_RUN_BIT] = r.run;
      end
    end

    // converter pins 1:0: routed pin is input only, no pulls
    for (int i = 0; i < 2; i++) begin
      next_r.pa_o[i] = r.pa_out[i];
      next_r.pa_oe[i] = r.pa_dir[i] & ~r.pa_func[i];
      next_r.conv_ch[i] = r.pa_func[i] & pa_s[i];
    end
    next_r.conv_sel = r.pa_func[1:0];
    // timer pins 3:2: routed pin follows the timer channel
    for (int i = 0; i < 2; i++) begin
      next_r.pa_o[i+2] = r.pa_func[i+2] ? timer_out_i[i] : r.pa_out[i+2];
      next_r.pa_oe[i+2] = r.pa_func[i+2] ? timer_oe_i[i] : r.pa_dir[i+2];
      next_r.timer_ch[i] = r.pa_func[i+2] & pa_s[i+2];
    end
    // pulldown replaces pullup only when allowed
    next_r.pa_pd = pd_eff;
    next_r.pa_pu = r.pa_pull_en & ~pd_eff & ~r.pa_func;

    // port B has pullups and nothing else
    next_r.pb_o = r.pb_out;
    next_r.pb_oe = r.pb_dir;
    next_r.pb_pu = r.pb_pull_en;

    // LF pins are cut off from the receiver while disabled
    next_r.lf_on = r.lf_en;
    next_r.lf_pos = r.lf_en & lf_pos_s;
    next_r.lf_neg = r.lf_en & lf_neg_s;

    // stop bits gate sources; no bit exists for the LOW_FREQ_OSCILLATOR
    next_r.clk_run = ~r.clk_stop;
    next_r.lfo_run = 1'b1;

    next_r.irq = |(next_r.irq_status & r.irq_mask);

    // strap: filtered pin is sampled one cycle after reset release
    next_r.vec_fetch = 1'b0;
    case (r.boot)
      pin_port_pkg::BOOT_HOLD: begin
        next_r.boot = pin_port_pkg::BOOT_SAMPLE;
      end
      pin_port_pkg::BOOT_SAMPLE: begin
        next_r.background_debug_mode = ~dbg_s;
        next_r.run = dbg_s;
        next_r.vec_fetch = dbg_s;
        next_r.start_addr = `RESET_PSEUDO_VECTOR;
        next_r.boot = pin_port_pkg::BOOT_DONE;
      end
      default: begin
        next_r.boot = pin_port_pkg::BOOT_DONE;
      end
    endcase
  end

  // single state register; reset forces constants
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.boot <= pin_port_pkg::BOOT_HOLD;
      r.pa_out <= `RST_PA;
      r.pa_dir <= `RST_PA;
      r.pa_pull_en <= `RST_PA;
      r.pa_pull_dn <= `RST_PA;
      r.pa_func <= `RST_PA;
      r.wake_en <= `RST_PA;
      r.pb_out <= `RST_PB;
      r.pb_dir <= `RST_PB;
      r.pb_pull_en <= `RST_PB;
      r.lf_en <= `RST_LF_EN;
      r.clk_stop <= `RST_CLK_STOP;
      r.clk_run <= ~`RST_CLK_STOP;
      r.irq_mask <= `RST_MASK;
      r.lfo_run <= 1'b1; // the LOW_FREQ_OSCILLATOR never stops, even in reset
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign port_a_pins_o = r.pa_o;
  assign port_a_pins_oe_o = r.pa_oe;
  assign port_a_pullup_o = r.pa_pu;
  assign port_a_pulldown_o = r.pa_pd;
  assign port_b_pins_o = r.pb_o;
  assign port_b_pins_oe_o = r.pb_oe;
  assign port_b_pullup_o = r.pb_pu;
  assign lf_pos_o = r.lf_pos;
  assign lf_neg_o = r.lf_neg;
  assign lf_receiver_enable_o = r.lf_on;
  assign conv_ch_o = r.conv_ch;
  assign conv_sel_o = r.conv_sel;
  assign timer_ch_o = r.timer_ch;
  assign clk_run_o = r.clk_run;
  assign lfo_run_o = r.lfo_run;
  assign bdm_mode_o = r.background_debug_mode;
  assign run_mode_o = r.run;
  assign vector_fetch_o = r.vec_fetch;
  assign start_addr_o = r.start_addr;
  assign irq_o = r.irq;

  // checks on the registered behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_pulldown_wake: assert property (
    (port_a_pulldown_o & ~$past(r.wake_en)) == 4'h0)
    else $error("pulldown active without wake enable");

  chk_conv_route: assert property (
    |$past(r.pa_func[1:0]) |-> ((port_a_pins_oe_o[1:0] & $past(r.pa_func[1:0])) == 2'h0
      && (conv_ch_o & $past(r.pa_func[1:0])) == ($past(pa_s[1:0]) & $past(r.pa_func[1:0]))))
    else $error("converter routing wrong");

  chk_timer_route: assert property (
    $past(r.pa_func[2]) |-> timer_ch_o[0] == $past(pa_s[2])
      && port_a_pins_oe_o[2] == $past(timer_oe_i[0]))
    else $error("timer routing wrong");

  chk_kbi_set: assert property (
    (kbi_set != 4'h0) |=> ((r.irq_status & $past(kbi_set)) == $past(kbi_set)))
    else $error("wake edge did not set its flag");

  chk_kbi_hold: assert property (
    (kbi_clr == 4'h0) |=> ((r.irq_status & $past(r.irq_status)) == $past(r.irq_status)))
    else $error("flag dropped without a clear");

  // depth one only: a deeper look-back would reach the unset state before reset
  chk_portb_pull: assert property (
    port_b_pullup_o == $past(r.pb_pull_en))
    else $error("port B pullup not following its register");

  chk_lf_gate: assert property (
    !lf_receiver_enable_o |-> !lf_pos_o && !lf_neg_o)
    else $error("LF input passed while disabled");

  chk_lfo_on: assert property (
    lfo_run_o && clk_run_o == ~$past(r.clk_stop))
    else $error("LOW_FREQ_OSCILLATOR stopped or clock enable wrong");

  chk_bdm_strap: assert property (
    r.boot == pin_port_pkg::BOOT_SAMPLE |=> bdm_mode_o == !$past(dbg_s) && bdm_mode_o != run_mode_o)
    else $error("strap mode capture wrong");

  chk_run_vector: assert property (
    $rose(run_mode_o) |-> vector_fetch_o && start_addr_o == `RESET_PSEUDO_VECTOR ##1 !vector_fetch_o)
    else $error("run mode without vector fetch pulse");
endmodule
`default_nettype wire

/* dv/pin_board.sv */
// board model: pin wiring, pulls, outside drivers, debug pod
// assumes drive and pull enables come straight from the port
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic clk_i, // bench clock
  input wire logic [5:0] drv_i, // port drive value {b,a}
  input wire logic [5:0] oe_i, // port drive enable
  input wire logic [5:0] pu_i, // pullup enable
  input wire logic [5:0] pd_i, // pulldown enable
  input wire logic [5:0] ext_en_i, // outside driver on
  input wire logic [5:0] ext_v_i, // outside driver value
  input wire logic pod_low_i, // pod pulls strap low
  output var logic [5:0] lvl_o, // resolved pin levels
  output var logic dbg_o // strap pin level
);
  logic tog = 1'b0;
  // a floating pin wanders, so a missing pull shows up
  always @(posedge clk_i) begin
    tog <= ~tog;
  end
  // resolve each wire; the port beats an outside driver
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (oe_i[i]) begin
        lvl_o[i] = drv_i[i];
      end else if (ext_en_i[i]) begin
        lvl_o[i] = ext_v_i[i];
      end else if (pu_i[i]) begin
        lvl_o[i] = 1'b1;
      end else if (pd_i[i]) begin
        lvl_o[i] = 1'b0;
      end else begin
        lvl_o[i] = tog ^ i[0];
      end
    end
  end
  // pod holds the strap low across reset release, else pullup
  assign dbg_o = pod_low_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* dv/pin_port_tb.sv */
// self-checking bench for the pin function port
// assumes the board model and the register offsets header
`timescale 1ns/1ps
`default_nettype none
`include "pin_port_cfg.svh"
module pin_port_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic lfp = 1'b0;
  logic lfn = 1'b0;
  logic pod_low = 1'b0;
  logic [1:0] tmo = 2'h0;
  logic [1:0] tmoe = 2'h0;
  logic [5:0] ext_en = 6'h00;
  logic [5:0] ext_v = 6'h00;
  logic [31:0] dat;
  logic ack, lfpo, lfno, lfe, low_freq_oscillator, background_debug_mode, run, vf, irq, dbg;
  logic [3:0] a_o, a_oe, a_pu, a_pd, clk_run;
  logic [1:0] b_o, b_oe, b_pu, conv_ch, conv_sel, tch;
  logic [15:0] saddr;
  logic [5:0] lvl;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  always #12.5 clk_i = ~clk_i;

  pin_port u_pin_port (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat), .wb_ack_o(ack), .port_a_pins_i(lvl[3:0]),
    .port_a_pins_o(a_o), .port_a_pins_oe_o(a_oe), .port_a_pullup_o(a_pu),
    .port_a_pulldown_o(a_pd), .port_b_pins_i(lvl[5:4]), .port_b_pins_o(b_o),
    .port_b_pins_oe_o(b_oe), .port_b_pullup_o(b_pu),
    .debug_mode_select_pin_i(dbg), .lf_input_pos_i(lfp), .lf_input_neg_i(lfn),
    .lf_pos_o(lfpo), .lf_neg_o(lfno), .lf_receiver_enable_o(lfe),
    .conv_ch_o(conv_ch), .conv_sel_o(conv_sel), .timer_out_i(tmo),
    .timer_oe_i(tmoe), .timer_ch_o(tch), .clk_run_o(clk_run), .lfo_run_o(low_freq_oscillator),
    .bdm_mode_o(background_debug_mode), .run_mode_o(run), .vector_fetch_o(vf),
    .start_addr_o(saddr), .irq_o(irq)
  );

  // port B has no pulldown wired at all
  pin_board u_pin_board (
    .clk_i(clk_i), .drv_i({b_o, a_o}), .oe_i({b_oe, a_oe}),
    .pu_i({b_pu, a_pu}), .pd_i({2'b00, a_pd}), .ext_en_i(ext_en),
    .ext_v_i(ext_v), .pod_low_i(pod_low), .lvl_o(lvl), .dbg_o(dbg)
  );

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask

  task automatic w8(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // reset with the strap set, then watch the mode capture
  task automatic boot(input logic low, input int n);
    pod_low <= low;
    rst_i <= 1'b1;
    w8(n);
    chk("lfo_rst", 32'h1, 32'(low_freq_oscillator));
    chk("clk_rst", 32'hF, 32'(clk_run));
    rst_i <= 1'b0;
    w8(2);
    #1;
    chk("bdm", 32'(low), 32'(background_debug_mode));
    chk("run", 32'(!low), 32'(run));
    chk("fetch", 32'(!low), 32'(vf));
    if (!low) chk("start", 32'hDFFE, 32'(saddr));
    w8(1);
    #1;
    chk("fetch_end", 32'h0, 32'(vf));
  endtask

  task automatic t_sys();
    lfp <= 1'b1;
    lfn <= 1'b1;
    wr(`OFF_SYS_CTRL, 32'h15);
    w8(8);
    chk("clk_run", 32'h5, 32'(clk_run));
    chk("lfe", 32'h1, 32'(lfe));
    chk("lf_pos", 32'h1, 32'(lfpo));
    chk("lf_neg", 32'h1, 32'(lfno));
    wr(`OFF_SYS_CTRL, 32'h1E);
    w8(8);
    chk("clk_all", 32'h0, 32'(clk_run));
    chk("lfo", 32'h1, 32'(low_freq_oscillator));
    chk("lf_off", 32'h0, 32'({lfpo, lfno}));
    rdc("sys", `OFF_SYS_CTRL, 32'h1E);
    rdc("unmapped", 8'h3C, 32'h0);
  endtask

  task automatic t_pulls();
    wr(`OFF_PA_PULL_EN, 32'hF);
    wr(`OFF_PA_PULL_DN, 32'hF);
    wr(`OFF_WAKE_EN, 32'h0);
    w8(3);
    chk("pd_nowake", 32'h0, 32'(a_pd));
    chk("pu_nowake", 32'hF, 32'(a_pu));
    wr(`OFF_WAKE_EN, 32'h3);
    w8(3);
    chk("pd_wake", 32'h3, 32'(a_pd));
    chk("pu_wake", 32'hC, 32'(a_pu));
    wr(`OFF_PA_DIR, 32'hF);
    wr(`OFF_PA_DATA, 32'h5);
    wr(`OFF_PB_PULL_EN, 32'h3);
    wr(`OFF_PB_DIR, 32'h1);
    wr(`OFF_PB_DATA, 32'h2);
    w8(8);
    chk("pa_oe", 32'hF, 32'(a_oe));
    rdc("pa_pins", `OFF_PA_DATA, 32'h5);
    chk("pb_pu", 32'h3, 32'(b_pu));
    rdc("pb_pins", `OFF_PB_DATA, 32'h2);
    wr(`OFF_PA_DIR, 32'h0);
  endtask

  // pin 1 masked out, pin 0 falls, pin 2 rises under pulldown
  task automatic t_wake();
    wr(`OFF_PA_PULL_DN, 32'h4);
    wr(`OFF_WAKE_EN, 32'hF);
    wr(`OFF_IRQ_MASK, 32'h1);
    w8(10);
    wb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    w8(3);
    chk("irq_idle", 32'h0, 32'(irq));
    ext_en <= 6'h02;
    w8(10);
    chk("irq_masked", 32'h0, 32'(irq));
    ext_en <= 6'h07;
    ext_v <= 6'h04;
    w8(10);
    ext_en <= 6'h00;
    w8(10);
    chk("irq_held", 32'h1, 32'(irq));
    rdc("status", `OFF_IRQ_STATUS, 32'h7);
    w8(2);
    chk("irq_clr", 32'h0, 32'(irq));
    rdc("status_clr", `OFF_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_route();
    wr(`OFF_PA_FUNC, 32'hF);
    tmo <= 2'b01;
    tmoe <= 2'b01;
    ext_en <= 6'h0B;
    ext_v <= 6'h0A;
    w8(10);
    chk("conv_sel", 32'h3, 32'(conv_sel));
    chk("conv_ch", 32'h2, 32'(conv_ch));
    chk("conv_pu", 32'h0, 32'(a_pu[1:0]));
    chk("tmr_oe", 32'h4, 32'(a_oe));
    chk("tmr_o", 32'h1, 32'(a_o[2]));
    chk("tmr_ch", 32'h3, 32'(tch));
    rdc("no_flag", `OFF_IRQ_STATUS, 32'h0);
    ext_en <= 6'h00;
    tmoe <= 2'b00;
    wr(`OFF_PA_FUNC, 32'h0);
  endtask

  initial begin
    boot(1'b0, 3);
    rdc("mode_run", `OFF_MODE_STATUS, 32'h2);
    t_sys();
    t_pulls();
    t_wake();
    t_route();
    boot(1'b1, 5);
    rdc("mode_bdm", `OFF_MODE_STATUS, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
